/* File: logic/sltp_pkg.sv */
package sltp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_TEST = 10'h205;
  localparam logic [9:0] IDX_IDENT = 10'h206;
  localparam logic [9:0] IDX_FRAME_CHARACTER_SETTING = 10'h207;
  localparam logic [9:0] IDX_CTRL = 10'h208;
  localparam logic [9:0] IDX_STAT = 10'h209;
  // Field positions and reset values
  localparam int TEST_MSB = 4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam logic [4:0] TEST_RST = 5'h00;
  localparam logic [7:0] IDENT_RST = 8'h00;
  localparam logic [7:0] FRAME_CHARACTER_SETTING_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h2;
  // Test selector codes
  localparam logic [4:0] TP_OFF = 5'h00;
  localparam logic [4:0] TP_PRBS7 = 5'h01;
  localparam logic [4:0] TP_PRBS15 = 5'h02;
  localparam logic [4:0] TP_PRBS23 = 5'h03;
  localparam logic [4:0] TP_RAMP = 5'h04;
  localparam logic [4:0] TP_TRANSPORT = 5'h05;
  localparam logic [4:0] TP_D21_5 = 5'h06;
  localparam logic [4:0] TP_K28_5 = 5'h07;
  localparam logic [4:0] TP_ILA = 5'h08;
  localparam logic [4:0] TP_RPAT = 5'h09;
  localparam logic [4:0] TP_LOW = 5'h0A;
  localparam logic [4:0] TP_HIGH = 5'h0B;
  localparam logic [4:0] TP_PRBS9 = 5'h0D;
  localparam logic [4:0] TP_PRBS31 = 5'h0E;
  localparam logic [4:0] TP_CLOCK = 5'h0F;
  localparam logic [4:0] TP_K28_7 = 5'h10;
  // Lane words and characters
  localparam logic [15:0] W_D21_5 = 16'hB5B5;
  localparam logic [15:0] W_K28_5 = 16'hBCBC;
  localparam logic [15:0] W_K28_7 = 16'hFCFC;
  localparam logic [15:0] W_CLOCK = 16'h00FF;
  localparam logic [15:0] W_LOW = 16'h0000;
  localparam logic [15:0] W_HIGH = 16'hFFFF;
  localparam logic [7:0] K_START = 8'h1C;
  localparam logic [7:0] K_END = 8'h7C;
  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
  localparam int ILA_MF = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ILA = 2'b01,
    ST_DATA = 2'b10,
    ST_TEST = 2'b11
  } sltp_state_t;
endpackage

/* File: logic/sltp_fifo.sv */
module sltp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty follow the registered count, so both are honest
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_q];

  ////////////////////////////////////////////////////////////////////////////
  // Storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= DEPTH)
    else $error("fifo count past depth");
endmodule

/* File: logic/sltp_ctrl.sv */
module sltp_ctrl #(
  parameter int LANES = 4,
  parameter int FRAMES = 4,
  parameter int DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic tx_ready,
  output logic [LANES*16-1:0] lane_data,
  output logic [LANES*2-1:0] lane_k,
  output logic lane_valid
);
  typedef logic [15:0] sltp_word_t;
  localparam int FW = $clog2(FRAMES);

  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic [4:0] test_q;
  logic [7:0] ident_q;
  logic [7:0] frame_character_setting_q;
  logic [1:0] ctrl_q;
  sltp_pkg::sltp_state_t state_q;
  logic [1:0] mf_q;
  logic [FW-1:0] fr_q;
  logic [30:0] prbs_q;
  logic [30:0] prbs_d;
  logic [15:0] cnt_q;
  logic en_q;
  sltp_word_t word_d;
  logic [1:0] k_d;
  sltp_word_t word_q;
  logic [1:0] k_q;
  logic lane_valid_q;
  logic lane_valid_p_q;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic addr_ok;
  logic rd_go;
  logic ila_last;
  logic step;
  logic code_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_go = addr_ok & !hwrite;

  // Read data is captured in the address phase and stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h00000000;
    end
    else if (rd_go)
    begin
      case (haddr[11:2])
        sltp_pkg::IDX_TEST: hrdata_q <= {27'h0000000, test_q};
        sltp_pkg::IDX_IDENT: hrdata_q <= {24'h000000, ident_q};
        sltp_pkg::IDX_FRAME_CHARACTER_SETTING: hrdata_q <= {24'h000000, frame_character_setting_q};
        sltp_pkg::IDX_CTRL: hrdata_q <= {30'h00000000, ctrl_q};
        sltp_pkg::IDX_STAT: hrdata_q <= {29'h00000000, state_q, fifo_valid};
        default: hrdata_q <= 32'h00000000; // Unmapped reads as zero
      endcase
    end
  end

  // Write address is held until the data phase brings hwdata
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
    end
    else
    begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
      begin
        wr_idx_q <= haddr[11:2];
      end
    end
  end

  // Register writes; upper bits of the test register are not stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      test_q <= sltp_pkg::TEST_RST;
      ident_q <= sltp_pkg::IDENT_RST;
      frame_character_setting_q <= sltp_pkg::FRAME_CHARACTER_SETTING_RST;
      ctrl_q <= sltp_pkg::CTRL_RST;
    end
    else if (wr_pend_q)
    begin
      case (wr_idx_q)
        sltp_pkg::IDX_TEST: test_q <= hwdata[sltp_pkg::TEST_MSB:0];
        sltp_pkg::IDX_IDENT: ident_q <= hwdata[7:0];
        sltp_pkg::IDX_FRAME_CHARACTER_SETTING: frame_character_setting_q <= hwdata[7:0];
        sltp_pkg::IDX_CTRL: ctrl_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer; back-pressure reaches the source through sample_ready
  sltp_fifo #(
    .WIDTH(16),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign step = tx_ready & ctrl_q[sltp_pkg::CTRL_EN_BIT];
  // Samples drain only in normal operation; test codes leave them queued
  assign fifo_pop = step & (state_q == sltp_pkg::ST_DATA);
  assign ila_last = (mf_q == 2'(sltp_pkg::ILA_MF - 1)) && (fr_q == FW'(FRAMES - 1));

  // Codes 7, 9 and 16 only count in 8B/10B mode, code 8 runs alignment in either mode; reserved codes send nothing
  always_comb
  begin
    case (test_q)
      sltp_pkg::TP_K28_5, sltp_pkg::TP_ILA, sltp_pkg::TP_RPAT, sltp_pkg::TP_K28_7:
        code_ok = ctrl_q[sltp_pkg::CTRL_MODE_BIT];
      5'h0C: code_ok = 1'b0;
      default: code_ok = (test_q < sltp_pkg::TP_K28_7) || (test_q == sltp_pkg::TP_K28_7);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer; settings are taken as static while enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= sltp_pkg::ST_IDLE;
      en_q <= 1'b0;
      mf_q <= 2'h0;
      fr_q <= '0;
    end
    else
    begin
      en_q <= ctrl_q[sltp_pkg::CTRL_EN_BIT];
      if (!ctrl_q[sltp_pkg::CTRL_EN_BIT])
      begin
        state_q <= sltp_pkg::ST_IDLE;
        mf_q <= 2'h0;
        fr_q <= '0;
      end
      else
      begin
        case (state_q)
          sltp_pkg::ST_IDLE:
          begin
            // Alignment first unless a plain test code bypasses it
            if (test_q == sltp_pkg::TP_OFF || test_q == sltp_pkg::TP_ILA)
            begin
              state_q <= sltp_pkg::ST_ILA;
            end
            else
            begin
              state_q <= sltp_pkg::ST_TEST;
            end
          end
          sltp_pkg::ST_ILA:
          begin
            if (tx_ready)
            begin
              fr_q <= (fr_q == FW'(FRAMES - 1)) ? '0 : fr_q + 1'b1;
              if (fr_q == FW'(FRAMES - 1))
              begin
                mf_q <= mf_q + 2'h1;
              end
              // Repeated alignment mode loops forever
              if (ila_last && test_q != sltp_pkg::TP_ILA)
              begin
                state_q <= sltp_pkg::ST_DATA;
              end
            end
          end
          sltp_pkg::ST_DATA: state_q <= sltp_pkg::ST_DATA;
          sltp_pkg::ST_TEST: state_q <= sltp_pkg::ST_TEST;
          default: state_q <= sltp_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen serial steps of the selected polynomial per lane word
  function automatic logic [30:0] prbs_adv(input logic [30:0] s, input logic [4:0] c);
    logic [30:0] t;
    logic b;
    t = s;
    b = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      case (c)
        sltp_pkg::TP_PRBS7: b = t[6] ^ t[5];
        sltp_pkg::TP_PRBS9: b = t[8] ^ t[4];
        sltp_pkg::TP_PRBS15: b = t[14] ^ t[13];
        sltp_pkg::TP_PRBS23: b = t[22] ^ t[17];
        default: b = t[30] ^ t[27];
      endcase
      t = {t[29:0], b};
    end
    return t;
  endfunction

  assign prbs_d = prbs_adv(prbs_q, test_q);

  // Generator state restarts each time the link is enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prbs_q <= sltp_pkg::PRBS_SEED;
      cnt_q <= 16'h0000;
    end
    else if (!en_q)
    begin
      prbs_q <= sltp_pkg::PRBS_SEED;
      cnt_q <= 16'h0000;
    end
    else if (tx_ready && state_q == sltp_pkg::ST_TEST)
    begin
      prbs_q <= prbs_d;
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane word selection
  always_comb
  begin
    word_d = word_q;
    k_d = 2'b00;
    if (state_q == sltp_pkg::ST_ILA)
    begin
      // Frame 0 starts each multiframe, the last frame ends it
      if (fr_q == '0)
      begin
        word_d = {sltp_pkg::K_START, sltp_pkg::K_START};
        k_d = 2'b11;
      end
      else if (fr_q == FW'(FRAMES - 1))
      begin
        word_d = {sltp_pkg::K_END, sltp_pkg::K_END};
        k_d = 2'b11;
      end
      else if (mf_q == 2'h1 && fr_q == FW'(1))
      begin
        word_d = {8'h00, ident_q};
      end
      else
      begin
        word_d = {6'h00, mf_q, 3'h0, fr_q[0], 4'h0};
      end
    end
    else if (state_q == sltp_pkg::ST_DATA)
    begin
      // Frame character fills gaps when no sample is queued
      word_d = fifo_valid ? fifo_data : {frame_character_setting_q, frame_character_setting_q};
    end
    else if (state_q == sltp_pkg::ST_TEST && code_ok)
    begin
      case (test_q)
        sltp_pkg::TP_PRBS7, sltp_pkg::TP_PRBS9, sltp_pkg::TP_PRBS15,
        sltp_pkg::TP_PRBS23, sltp_pkg::TP_PRBS31: word_d = prbs_d[15:0];
        sltp_pkg::TP_RAMP: word_d = cnt_q;
        sltp_pkg::TP_TRANSPORT: word_d = {cnt_q[7:0], ~cnt_q[7:0]};
        sltp_pkg::TP_D21_5: word_d = sltp_pkg::W_D21_5;
        sltp_pkg::TP_K28_5:
        begin
          word_d = sltp_pkg::W_K28_5;
          k_d = 2'b11;
        end
        sltp_pkg::TP_K28_7:
        begin
          word_d = sltp_pkg::W_K28_7;
          k_d = 2'b11;
        end
        sltp_pkg::TP_RPAT:
        begin
          // Short fixed cycle rich in transitions and run lengths
          case (cnt_q[1:0])
            2'h0: word_d = 16'hBE14;
            2'h1: word_d = 16'hD7A6;
            2'h2: word_d = 16'h4178;
            default: word_d = 16'h0BC3;
          endcase
        end
        sltp_pkg::TP_LOW: word_d = sltp_pkg::W_LOW;
        sltp_pkg::TP_HIGH: word_d = sltp_pkg::W_HIGH;
        sltp_pkg::TP_CLOCK: word_d = sltp_pkg::W_CLOCK;
        default: word_d = sltp_pkg::W_LOW;
      endcase
    end
    else
    begin
      word_d = sltp_pkg::W_LOW;
    end
  end

  // Common word register; it advances when the serializer takes a word, and every cycle while the link is disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      word_q <= 16'h0000;
      k_q <= 2'b00;
      lane_valid_p_q <= 1'b0;
      lane_valid_q <= 1'b0;
    end
    else
    begin
      // Valid is piped twice so it lines up with the lane flops, not with word_q
      lane_valid_p_q <= step && state_q != sltp_pkg::ST_IDLE;
      lane_valid_q <= lane_valid_p_q;
      if (!ctrl_q[sltp_pkg::CTRL_EN_BIT] || tx_ready)
      begin
        word_q <= word_d;
        k_q <= k_d;
      end
    end
  end

  // Every active lane carries the same word
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [15:0] ld_q;
      logic [1:0] lk_q;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          ld_q <= 16'h0000;
          lk_q <= 2'b00;
        end
        else
        begin
          ld_q <= word_q;
          lk_q <= k_q;
        end
      end
      assign lane_data[g*16 +: 16] = ld_q;
      assign lane_k[g*2 +: 2] = lk_q;
    end
  endgenerate
  assign lane_valid = lane_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DATA_ONLY_ZERO: assert property (state_q == sltp_pkg::ST_DATA |-> test_q == sltp_pkg::TP_OFF)
    else $error("normal data with a test code set");
  AST_PRBS_WORD: assert property (state_q == sltp_pkg::ST_TEST && tx_ready && code_ok
    && test_q == sltp_pkg::TP_PRBS31 |=> ##1 lane_data[15:0] == $past(prbs_d[15:0], 2))
    else $error("prbs word not sent");
  AST_D21_5: assert property (state_q == sltp_pkg::ST_TEST && tx_ready
    && test_q == sltp_pkg::TP_D21_5 |=> ##1 lane_data[15:0] == sltp_pkg::W_D21_5)
    else $error("D21.5 word wrong");
  AST_K28_5: assert property (state_q == sltp_pkg::ST_TEST && tx_ready && ctrl_q[1]
    && test_q == sltp_pkg::TP_K28_5 |=> ##1 lane_k[1:0] == 2'b11)
    else $error("K28.5 not flagged as control");
  AST_HELD_LEVEL: assert property (state_q == sltp_pkg::ST_TEST && tx_ready
    && test_q == sltp_pkg::TP_HIGH |=> ##1 lane_data[15:0] == sltp_pkg::W_HIGH)
    else $error("lanes not held high");
  AST_CLOCK_WORD: assert property (state_q == sltp_pkg::ST_TEST && tx_ready
    && test_q == sltp_pkg::TP_CLOCK |=> ##1 lane_data[15:0] == sltp_pkg::W_CLOCK)
    else $error("clock word wrong");
  AST_IDENT_SLOT: assert property (state_q == sltp_pkg::ST_ILA && tx_ready && mf_q == 2'h1
    && fr_q == FW'(1) |=> ##1 lane_data[7:0] == $past(ident_q, 2))
    else $error("identifier missing from second multiframe");
  AST_NO_DRAIN_IN_TEST: assert property (state_q == sltp_pkg::ST_TEST |-> !fifo_pop)
    else $error("samples drained in test mode");
  AST_RESERVED_SILENT: assert property (state_q == sltp_pkg::ST_TEST && tx_ready
    && test_q == 5'h0C |=> ##1 lane_data[15:0] == sltp_pkg::W_LOW)
    else $error("reserved code sent a pattern");

  COV_DATA: cover property (state_q == sltp_pkg::ST_ILA ##1 state_q == sltp_pkg::ST_DATA);
  COV_PRBS7: cover property (state_q == sltp_pkg::ST_TEST && test_q == sltp_pkg::TP_PRBS7);
  COV_FIFO_FULL: cover property (sample_valid && !sample_ready);
endmodule

/* File: sim/sltp_rx_model.sv */
////////////////////////////////////////////////////////////////////////////////
// Receiver stand-in: paces the lanes and checks that all lanes agree
module sltp_rx_model #(
  parameter int LANES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [LANES*16-1:0] lane_data,
  input wire logic lane_valid,
  input wire logic slow,
  output logic tx_ready,
  output logic lanes_equal
);
  timeunit 1ns;
  timeprecision 100ps;

  // Slow mode stalls about one cycle in four, so held words are exercised
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? ($urandom % 4 != 0) : 1'b1;
  end

  // Every active lane must carry the same word as lane zero
  always_comb
  begin
    lanes_equal = 1'b1;
    for (int g = 1; g < LANES; g++)
      if (lane_data[g*16+:16] !== lane_data[15:0])
        lanes_equal = 1'b0;
  end
endmodule

/* File: sim/sltp_ctrl_tb.sv */
`define CHK(a, b) do begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end while (0)
////////////////////////////////////////////////////////////////////////////////
module sltp_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ILA_LEN = sltp_pkg::ILA_MF * 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] sample_data = 16'h0;
  logic sample_valid = 1'b0;
  logic slow = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sample_ready;
  logic tx_ready;
  logic [63:0] lane_data;
  logic [7:0] lane_k;
  logic lane_valid;
  logic lanes_equal;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rd_q[$];
  logic [15:0] smp_q[$];
  logic rd_pend = 1'b0;
  int mon_mode = 0;
  int wi = 0;
  int nb = 0;
  int pa = 7;
  int pb = 6;
  int cnt;
  logic have_prev = 1'b0;
  logic [15:0] w;
  logic [15:0] e;
  logic [15:0] exp_w = 16'h0;
  logic [15:0] prev_w;
  logic [63:0] hist;
  logic [63:0] h;
  logic [7:0] ident;
  logic [7:0] frame_character_setting = 8'hA7;
  logic [31:0] exp_rd;

  sltp_ctrl #(.LANES(4), .FRAMES(4), .DEPTH(16)) sltp_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .tx_ready(tx_ready), .lane_data(lane_data), .lane_k(lane_k), .lane_valid(lane_valid)
  );

  sltp_rx_model #(.LANES(4)) sltp_rx_model_inst (
    .hclk(hclk), .hresetn(hresetn), .lane_data(lane_data), .lane_valid(lane_valid),
    .slow(slow), .tx_ready(tx_ready), .lanes_equal(lanes_equal)
  );

  always #12.5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////////
  // One single AHB transfer; the request stands until hready is seen high
  task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] x);
    rd_q.push_back(x);
    bus(idx, 1'b0, 32'h0);
  endtask

  function automatic logic [15:0] nxt();
    logic [15:0] r;
    r = 16'($urandom);
    return (r == {frame_character_setting, frame_character_setting}) ? 16'h0001 : r; // Never look like idle filler
  endfunction

  // Selector is changed only with the link disabled, upper bits kept zero
  task automatic run_code(input logic [4:0] c, input int m, input logic [15:0] x, input int a, input int b,
                          input int ncyc);
    bus(sltp_pkg::IDX_CTRL, 1'b1, 32'h2);
    bus(sltp_pkg::IDX_TEST, 1'b1, {27'h0, c});
    rd(sltp_pkg::IDX_TEST, {27'h0, c});
    mon_mode <= m;
    wi <= 0;
    nb <= 0;
    have_prev <= 1'b0;
    exp_w <= x;
    pa <= a;
    pb <= b;
    slow <= 1'($urandom % 2);
    bus(sltp_pkg::IDX_CTRL, 1'b1, 32'h3);
    repeat (ncyc) @(posedge hclk);
    mon_mode <= 0;
  endtask

  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever a read completes or a non-filler word follows alignment in mode 6
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      // Pop once; the macro reads its arguments more than once
      exp_rd = rd_q.pop_front();
      `CHK(hrdata, exp_rd);
    end
    if (lane_valid === 1'b1 && mon_mode != 0)
    begin
      w = lane_data[15:0];
      `CHK(lanes_equal, 1'b1);
      case (mon_mode)
        1:
        begin
          `CHK(w, exp_w);
          `CHK(lane_k[1:0], {2{exp_w == sltp_pkg::W_K28_5 || exp_w == sltp_pkg::W_K28_7}});
        end
        2: if (have_prev) `CHK(w, prev_w + 16'h1);
        3: `CHK(w[15:8], ~w[7:0]);
        4:
        begin
          h = hist;
          for (int k = 15; k >= 0; k--)
          begin
            e[k] = h[pa-1] ^ h[pb-1];
            h = {h[62:0], w[k]};
          end
          if (nb >= 2) `CHK(w, e);
          hist = h;
          nb++;
        end
        5, 6:
        begin
          if (mon_mode == 5 || wi < ILA_LEN)
          begin
            if (wi % ILA_LEN == 0) `CHK(w, {sltp_pkg::K_START, sltp_pkg::K_START});
            if (wi % ILA_LEN == 5) `CHK(w, {8'h00, ident});
          end
          else if (w !== {frame_character_setting, frame_character_setting})
          begin
            e = (smp_q.size() > 0) ? smp_q.pop_front() : {frame_character_setting, frame_character_setting};
            `CHK(w, e);
          end
          wi++;
        end
        default: ;
      endcase
      prev_w = w;
      have_prev = 1'b1;
    end
  end

  // Watchdog, sized well above the whole sequence
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h5a0da40c));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(sltp_pkg::IDX_TEST, 32'h0);
    rd(sltp_pkg::IDX_IDENT, 32'h0);
    rd(sltp_pkg::IDX_FRAME_CHARACTER_SETTING, 32'h0);
    rd(sltp_pkg::IDX_CTRL, 32'h2);
    rd(10'h300, 32'h0);
    ident = 8'($urandom);
    bus(sltp_pkg::IDX_IDENT, 1'b1, {24'h0, ident});
    bus(sltp_pkg::IDX_FRAME_CHARACTER_SETTING, 1'b1, {24'h0, frame_character_setting});
    rd(sltp_pkg::IDX_IDENT, {24'h0, ident});
    rd(sltp_pkg::IDX_FRAME_CHARACTER_SETTING, {24'h0, frame_character_setting});
    // Fill the FIFO while the link is off, pushing past full
    cnt = 0;
    sample_valid <= 1'b1;
    sample_data <= nxt();
    repeat (24)
    begin
      @(posedge hclk);
      if (sample_ready === 1'b1)
      begin
        smp_q.push_back(sample_data);
        cnt++;
        sample_data <= nxt();
      end
    end
    sample_valid <= 1'b0;
    `CHK(cnt, 16);
    run_code(5'h00, 6, 16'h0, 0, 0, 200);
    `CHK(smp_q.size(), 0);
    run_code(sltp_pkg::TP_PRBS7, 4, 16'h0, 7, 6, 60);
    run_code(sltp_pkg::TP_PRBS9, 4, 16'h0, 9, 5, 60);
    run_code(sltp_pkg::TP_PRBS15, 4, 16'h0, 15, 14, 60);
    run_code(sltp_pkg::TP_PRBS23, 4, 16'h0, 23, 18, 60);
    run_code(sltp_pkg::TP_PRBS31, 4, 16'h0, 31, 28, 60);
    run_code(sltp_pkg::TP_RAMP, 2, 16'h0, 0, 0, 60);
    run_code(sltp_pkg::TP_TRANSPORT, 3, 16'h0, 0, 0, 60);
    run_code(sltp_pkg::TP_D21_5, 1, sltp_pkg::W_D21_5, 0, 0, 40);
    run_code(sltp_pkg::TP_K28_5, 1, sltp_pkg::W_K28_5, 0, 0, 40);
    run_code(sltp_pkg::TP_K28_7, 1, sltp_pkg::W_K28_7, 0, 0, 40);
    run_code(sltp_pkg::TP_ILA, 5, 16'h0, 0, 0, 80);
    run_code(sltp_pkg::TP_RPAT, 7, 16'h0, 0, 0, 40);
    run_code(sltp_pkg::TP_LOW, 1, sltp_pkg::W_LOW, 0, 0, 40);
    run_code(sltp_pkg::TP_HIGH, 1, sltp_pkg::W_HIGH, 0, 0, 40);
    run_code(sltp_pkg::TP_CLOCK, 1, sltp_pkg::W_CLOCK, 0, 0, 40);
    repeat (4) @(posedge hclk);
    close_out();
  end
endmodule
